// >>> logic/output_setpoint_fault_manager.sv
// Setpoint selection, output clamp, voltage and current fault handling and power-good
`include "ospfm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module output_setpoint_fault_manager #(
   parameter logic [31:0] HICCUP_TICKS = `HICCUP_US
)(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire ospfm_pkg::wb_req_type WB_REQ,
   output logic WB_ACK,
   output logic [31:0] WB_DAT_O,
   input wire logic [3:0] STRAP_SENSE_PIN,
   input wire logic CTRL_PIN,
   input wire logic OVERCURRENT_PIN,
   input wire logic [15:0] VOUT_SENSE,
   input wire logic RAMP_DONE,
   input wire logic CAL_DONE,
   output logic OUTPUT_ENABLE,
   output logic [15:0] TARGET,
   output logic CAL_START,
   output logic POWER_GOOD_OUT,
   output logic POWER_GOOD_OE
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   ospfm_pkg::state_type q;
   ospfm_pkg::state_type next_q;

   // Nominal level in millivolts per strap code
   function automatic logic [15:0] strap_level(input logic [3:0] code);
      logic [15:0] lv;
      lv = 16'h0258;
      case (code)
         4'h0: lv = 16'h0258;
         4'h1: lv = 16'h02bc;
         4'h2: lv = 16'h02ee;
         4'h3: lv = 16'h0320;
         4'h4: lv = 16'h0352;
         4'h5: lv = 16'h0384;
         4'h6: lv = 16'h03e8;
         4'h7: lv = 16'h041a;
         4'h8: lv = 16'h044c;
         4'h9: lv = 16'h04b0;
         4'ha: lv = 16'h05dc;
         4'hb: lv = 16'h0708;
         4'hc: lv = 16'h09c4;
         4'hd: lv = 16'h0ce4;
         4'he: lv = 16'h0fa0;
         default: lv = 16'h1388;
      endcase
      return lv;
   endfunction : strap_level

   // Percentage of a level, truncated
   function automatic logic [15:0] pct(input logic [15:0] v, input logic [31:0] p);
      logic [31:0] prod;
      prod = ({16'h0000, v} * p) / 32'd100;
      return prod[15:0];
   endfunction : pct

   // Byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input ospfm_pkg::wb_req_type r);
      logic [15:0] m;
      m = old;
      if (r.sel[0])
         m[7:0] = r.dat[7:0];
      if (r.sel[1])
         m[15:8] = r.dat[15:8];
      return m;
   endfunction : merge

   // One step of a voltage fault response
   function automatic ospfm_pkg::vres_type vstep(input logic [1:0] resp, input logic present,
                                                 input logic [15:0] cnt, input logic lat,
                                                 input logic clr, input logic [15:0] dly,
                                                 input logic tick);
      ospfm_pkg::vres_type r;
      logic set;
      set = 1'b0;
      r.cnt = 16'h0000;
      if (present && resp == `VRESP_LATCH)
         set = 1'b1;
      if (present && resp == `VRESP_DELAY)
      begin
         if (cnt >= dly)
            set = 1'b1;
         else
            r.cnt = cnt + {15'h0000, tick};
      end
      r.lat = set | (lat & ~clr);
      r.off = r.lat | (present && resp == `VRESP_AUTO);
      return r;
   endfunction : vstep

   // ----------------------------------------
   // Combinational next state
   // ----------------------------------------
   logic [15:0] nom;
   logic wr;
   logic rd_strobe;
   logic en_req;
   logic en_rise;
   logic [2:0] clr;
   logic ov_now;
   logic uv_now;
   logic oc_now;
   logic [15:0] base;
   logic signed [17:0] sum;
   ospfm_pkg::vres_type ovr;
   ospfm_pkg::vres_type uvr;
   logic hic_start;
   logic oc_set;
   logic fault_any;

   always_comb
   begin
      next_q = q;
      nom = strap_level(q.strap_s);
      rd_strobe = WB_REQ.cyc & WB_REQ.stb & ~q.ack;
      // Writes land at the edge where the master samples ack high
      wr = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & q.ack & (q.phase == ospfm_pkg::ST_RUN);
      // Pin synchronisers
      next_q.strap_m = STRAP_SENSE_PIN;
      next_q.strap_s = q.strap_m;
      next_q.ctrl_m = CTRL_PIN;
      next_q.ctrl_s = q.ctrl_m;
      next_q.oc_m = OVERCURRENT_PIN;
      next_q.oc_s = q.oc_m;
      // Microsecond tick divider
      next_q.tick = 1'b0;
      next_q.div = q.div + 8'h01;
      if (q.div == 8'(`TICK_CYCLES - 32'd1))
      begin
         next_q.div = 8'h00;
         next_q.tick = 1'b1;
      end
      // Power-up sequence: wait for synchronisers, then catch the strap once
      case (q.phase)
         ospfm_pkg::ST_SYNC:
         begin
            next_q.sync_cnt = q.sync_cnt + 2'h1;
            if (q.sync_cnt == 2'h3)
               next_q.phase = ospfm_pkg::ST_LOAD;
         end
         ospfm_pkg::ST_LOAD:
         begin
            next_q.strap = q.strap_s;
            next_q.vcmd = nom;
            next_q.mhigh = pct(nom, `MH_PCT);
            next_q.mlow = pct(nom, `ML_PCT);
            next_q.vmax = (pct(nom, `VMAX_PCT) < `VMAX_ABS_MV) ? pct(nom, `VMAX_PCT) : `VMAX_ABS_MV;
            next_q.ovlim = pct(nom, `OV_PCT);
            next_q.uvlim = pct(nom, `UV_PCT);
            next_q.pgon = pct(nom, `PGON_PCT);
            next_q.pgoff = pct(nom, `PGOFF_PCT);
            next_q.phase = ospfm_pkg::ST_RUN;
         end
         ospfm_pkg::ST_RUN:
            next_q.phase = ospfm_pkg::ST_RUN;
         default:
            next_q.phase = ospfm_pkg::ST_SYNC;
      endcase
      // Register writes
      clr = 3'h0;
      if (wr)
      begin
         case (WB_REQ.adr)
            `ADR_CTRL:
               if (WB_REQ.sel[0])
               begin
                  next_q.bus_en = WB_REQ.dat[0];
                  next_q.margin = WB_REQ.dat[2:1];
               end
            `ADR_VCMD: next_q.vcmd = merge(q.vcmd, WB_REQ);
            `ADR_TRIM: next_q.trim = merge(q.trim, WB_REQ);
            `ADR_MHIGH: next_q.mhigh = merge(q.mhigh, WB_REQ);
            `ADR_MLOW: next_q.mlow = merge(q.mlow, WB_REQ);
            `ADR_VMAX: next_q.vmax = merge(q.vmax, WB_REQ);
            `ADR_OVLIM: next_q.ovlim = merge(q.ovlim, WB_REQ);
            `ADR_UVLIM: next_q.uvlim = merge(q.uvlim, WB_REQ);
            `ADR_PGON: next_q.pgon = merge(q.pgon, WB_REQ);
            `ADR_PGOFF: next_q.pgoff = merge(q.pgoff, WB_REQ);
            `ADR_RESP:
               if (WB_REQ.sel[0])
                  next_q.resp = WB_REQ.dat[5:0];
            `ADR_DELAY: next_q.delay = merge(q.delay, WB_REQ);
            `ADR_STATUS:
               if (WB_REQ.sel[0])
                  clr = WB_REQ.dat[2:0];
            default: clr = 3'h0;
         endcase
      end
      // Enable request and re-enable edge
      en_req = q.bus_en & q.ctrl_s & (q.phase == ospfm_pkg::ST_RUN);
      en_rise = en_req & ~q.en_d;
      next_q.en_d = en_req;
      // Fault detection; under-voltage and current armed after ramp-up
      ov_now = VOUT_SENSE > q.ovlim;
      uv_now = RAMP_DONE & (VOUT_SENSE < q.uvlim);
      oc_now = RAMP_DONE & q.oc_s;
      ovr = vstep(q.resp[1:0], ov_now, q.ov_cnt, q.ov_lat, clr[0] | en_rise, q.delay, q.tick);
      uvr = vstep(q.resp[3:2], uv_now, q.uv_cnt, q.uv_lat, clr[1] | en_rise, q.delay, q.tick);
      next_q.ov_cnt = ovr.cnt;
      next_q.uv_cnt = uvr.cnt;
      next_q.ov_lat = ovr.lat;
      next_q.uv_lat = uvr.lat;
      // Over-current: only ignore, latch or hiccup exist
      oc_set = oc_now & (q.resp[5:4] == `ORESP_LATCH);
      next_q.oc_lat = oc_set | (q.oc_lat & ~(clr[2] | en_rise));
      hic_start = oc_now & (q.resp[5:4] == `ORESP_HICCUP) & ~q.hic;
      next_q.hic_cnt = q.hic_cnt;
      if (hic_start)
      begin
         next_q.hic = 1'b1;
         next_q.hic_cnt = 32'h0000_0000;
      end
      else if (q.hic && q.tick)
      begin
         next_q.hic_cnt = q.hic_cnt + 32'h0000_0001;
         if (q.hic_cnt >= HICCUP_TICKS - 32'd1)
            next_q.hic = 1'b0;
      end
      // Output switch
      next_q.out_on = en_req & ~ovr.off & ~uvr.off & ~next_q.oc_lat & ~next_q.hic;
      // Calibration after each ramp-up
      next_q.ramp_d = RAMP_DONE;
      next_q.cal_start = RAMP_DONE & ~q.ramp_d & q.out_on;
      if (!q.out_on || !RAMP_DONE)
         next_q.cal_ok = 1'b0;
      else if (CAL_DONE)
         next_q.cal_ok = 1'b1;
      // Power-good with hysteresis
      fault_any = ov_now | uv_now | oc_now | ovr.off | uvr.off | next_q.oc_lat | next_q.hic;
      if (!next_q.out_on || fault_any || VOUT_SENSE < q.pgoff)
         next_q.good = 1'b0;
      else if (RAMP_DONE && q.cal_ok && VOUT_SENSE > q.pgon)
         next_q.good = 1'b1;
      next_q.good_oe = ~next_q.good;
      // Target: margin select, then trim, then clamp
      case (q.margin)
         `MARGIN_HIGH: base = q.mhigh;
         `MARGIN_LOW: base = q.mlow;
         default: base = q.vcmd;
      endcase
      sum = $signed({2'b00, base}) + $signed({{2{q.trim[15]}}, q.trim});
      if (sum < 18'sd0)
         next_q.target = 16'h0000;
      else if (sum > $signed({2'b00, q.vmax}))
         next_q.target = q.vmax;
      else
         next_q.target = sum[15:0];
      // Wishbone answer, one cycle after the strobe
      next_q.ack = rd_strobe;
      next_q.rdata = 32'h0000_0000;
      if (rd_strobe && !WB_REQ.we)
      begin
         case (WB_REQ.adr)
            `ADR_CTRL: next_q.rdata = {29'h0, q.margin, q.bus_en};
            `ADR_VCMD: next_q.rdata = {16'h0000, q.vcmd};
            `ADR_TRIM: next_q.rdata = {16'h0000, q.trim};
            `ADR_MHIGH: next_q.rdata = {16'h0000, q.mhigh};
            `ADR_MLOW: next_q.rdata = {16'h0000, q.mlow};
            `ADR_VMAX: next_q.rdata = {16'h0000, q.vmax};
            `ADR_OVLIM: next_q.rdata = {16'h0000, q.ovlim};
            `ADR_UVLIM: next_q.rdata = {16'h0000, q.uvlim};
            `ADR_PGON: next_q.rdata = {16'h0000, q.pgon};
            `ADR_PGOFF: next_q.rdata = {16'h0000, q.pgoff};
            `ADR_RESP: next_q.rdata = {26'h0, q.resp};
            `ADR_DELAY: next_q.rdata = {16'h0000, q.delay};
            `ADR_STATUS: next_q.rdata = {12'h000, q.strap, 10'h000, q.hic, q.out_on, q.good,
                                         q.oc_lat, q.uv_lat, q.ov_lat};
            `ADR_TARGET: next_q.rdata = {16'h0000, q.target};
            default: next_q.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         q <= '0;
         {q.margin, q.bus_en} <= `CTRL_RESET;
         q.resp <= `RESP_RESET;
         q.delay <= `DELAY_RESET;
         q.good_oe <= 1'b1;
      end
      else
         q <= next_q;
   end

   // Outputs straight from the state register, except POWER_GOOD_OUT which is tied low
   assign WB_ACK = q.ack;
   assign WB_DAT_O = q.rdata;
   assign OUTPUT_ENABLE = q.out_on;
   assign TARGET = q.target;
   assign CAL_START = q.cal_start;
   assign POWER_GOOD_OUT = 1'b0;
   assign POWER_GOOD_OE = q.good_oe;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence ov_auto_seq;
      q.phase == ospfm_pkg::ST_RUN && VOUT_SENSE > q.ovlim && q.resp[1:0] == `VRESP_AUTO;
   endsequence

   strap_held_a: assert property (q.phase == ospfm_pkg::ST_RUN |=> $stable(q.strap))
      else $error("strap level changed after power-up");
   target_clamp_a: assert property (q.phase == ospfm_pkg::ST_RUN ##1 1'b1 |-> TARGET <= $past(q.vmax))
      else $error("target above maximum");
   target_cmd_a: assert property (q.margin == 2'h0 && q.trim == 16'h0000 && q.vcmd <= q.vmax
                                  |=> TARGET == $past(q.vcmd))
      else $error("zero trim changed the target");
   ov_auto_a: assert property (ov_auto_seq |=> !OUTPUT_ENABLE)
      else $error("auto response left output on");
   ov_latch_a: assert property (q.ov_lat && !en_rise && !(wr && WB_REQ.adr == `ADR_STATUS)
                                |=> q.ov_lat && !OUTPUT_ENABLE)
      else $error("latched fault released on its own");
   good_fault_a: assert property (fault_any |=> POWER_GOOD_OE == 1'b1)
      else $error("power good high during a fault");
   good_cal_a: assert property ($fell(POWER_GOOD_OE) |-> $past(q.cal_ok) && $past(RAMP_DONE))
      else $error("power good without calibration");
   oc_arm_a: assert property (!RAMP_DONE && !q.oc_lat |=> !q.oc_lat && !$rose(q.hic))
      else $error("current fault before ramp-up");
   hiccup_off_a: assert property (hic_start |=> !OUTPUT_ENABLE ##1 q.hic)
      else $error("hiccup did not shut down");
   ack_pulse_a: assert property (WB_ACK |=> !WB_ACK)
      else $error("ack held two cycles");
endmodule : output_setpoint_fault_manager
`default_nettype wire

// >>> logic/ospfm_cfg.svh
// Offsets, field codes, reset values and timing counts of the setpoint manager
`ifndef OSPFM_CFG_SVH
`define OSPFM_CFG_SVH
`define ADR_CTRL 8'h00
`define ADR_VCMD 8'h04
`define ADR_TRIM 8'h08
`define ADR_MHIGH 8'h0c
`define ADR_MLOW 8'h10
`define ADR_VMAX 8'h14
`define ADR_OVLIM 8'h18
`define ADR_UVLIM 8'h1c
`define ADR_PGON 8'h20
`define ADR_PGOFF 8'h24
`define ADR_RESP 8'h28
`define ADR_DELAY 8'h2c
`define ADR_STATUS 8'h30
`define ADR_TARGET 8'h34
`define CTRL_RESET 3'h1
`define RESP_RESET 6'h2f
`define DELAY_RESET 16'h000a
`define MARGIN_LOW 2'h1
`define MARGIN_HIGH 2'h2
`define VRESP_IGNORE 2'h0
`define VRESP_DELAY 2'h1
`define VRESP_LATCH 2'h2
`define VRESP_AUTO 2'h3
`define ORESP_LATCH 2'h1
`define ORESP_HICCUP 2'h2
`define MH_PCT 32'd105
`define ML_PCT 32'd95
`define VMAX_PCT 32'd110
`define VMAX_ABS_MV 16'h157c
`define OV_PCT 32'd115
`define UV_PCT 32'd85
`define PGON_PCT 32'd90
`define PGOFF_PCT 32'd85
`define CLK_NS 32'd10
`define TICK_NS 32'd1000
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define HICCUP_US 32'd20000
`endif

// >>> logic/ospfm_pkg.sv
// Types of the output setpoint and fault manager
package ospfm_pkg;
   typedef enum logic [1:0] {ST_SYNC = 2'b00, ST_LOAD = 2'b01, ST_RUN = 2'b10} phase_type;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;
   typedef struct packed {
      logic [15:0] cnt;
      logic lat;
      logic off;
   } vres_type;
   typedef struct packed {
      phase_type phase;
      logic [1:0] sync_cnt;
      logic [3:0] strap_m;
      logic [3:0] strap_s;
      logic ctrl_m;
      logic ctrl_s;
      logic oc_m;
      logic oc_s;
      logic [3:0] strap;
      logic [15:0] vcmd;
      logic [15:0] trim;
      logic [15:0] mhigh;
      logic [15:0] mlow;
      logic [15:0] vmax;
      logic [15:0] ovlim;
      logic [15:0] uvlim;
      logic [15:0] pgon;
      logic [15:0] pgoff;
      logic [5:0] resp;
      logic [15:0] delay;
      logic bus_en;
      logic [1:0] margin;
      logic [7:0] div;
      logic tick;
      logic [15:0] ov_cnt;
      logic [15:0] uv_cnt;
      logic ov_lat;
      logic uv_lat;
      logic oc_lat;
      logic hic;
      logic [31:0] hic_cnt;
      logic en_d;
      logic ramp_d;
      logic cal_ok;
      logic cal_start;
      logic out_on;
      logic good;
      logic good_oe;
      logic [15:0] target;
      logic ack;
      logic [31:0] rdata;
   } state_type;
endpackage : ospfm_pkg

// >>> tb/ospfm_load_model.sv
// Power stage and load model: sensed output, ramp and calibration status
`timescale 1ns/1ps
`default_nettype none
module ospfm_load_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic out_en,
   input wire logic [15:0] target,
   input wire logic cal_start,
   input wire logic force_en,
   input wire logic [15:0] force_mv,
   output logic [15:0] vout,
   output logic ramp_done,
   output logic cal_done
);
   logic [5:0] cnt;
   logic [3:0] cal_cnt;
   // ------------------------------------------------------------
   // Ramp and calibration progress
   // ------------------------------------------------------------
   // Both restart whenever the stage is switched off
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         {cnt, cal_cnt, ramp_done, cal_done} <= '0;
      else if (!out_en)
         {cnt, cal_cnt, ramp_done, cal_done} <= '0;
      else
      begin
         cnt <= (cnt == 6'h14) ? cnt : cnt + 6'h01;
         ramp_done <= (cnt == 6'h14);
         cal_cnt <= cal_start ? 4'h1 : (cal_cnt != 4'h0 && cal_cnt != 4'ha) ? cal_cnt + 4'h1 : cal_cnt;
         cal_done <= (cal_cnt == 4'ha);
      end
   end
   // Half of target while ramping, forced level when the bench injects a fault
   assign vout = force_en ? force_mv : !out_en ? 16'h0000 : ramp_done ? target : {1'b0, target[15:1]};
endmodule : ospfm_load_model
`default_nettype wire

// >>> tb/output_setpoint_fault_manager_tb_top.sv
// Self-checking bench of the output setpoint and fault manager
`include "ospfm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module output_setpoint_fault_manager_tb_top;
   // ------------------------------------------------------------
   // Stimulus, design and load model
   // ------------------------------------------------------------
   localparam logic [31:0] NOM = 32'h3e8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   ospfm_pkg::wb_req_type req = '0;
   logic ctrl = 1'b0;
   logic oc = 1'b0;
   logic [3:0] strap = 4'h6;
   logic force_en = 1'b0;
   logic [15:0] force_mv = 16'h0000;
   logic ack, oe, cal_start, ramp_done, cal_done, good_out, good_oe, good_pin;
   logic [31:0] rdat, d;
   logic [15:0] vout, target;
   int fails = 0;
   int samples_checked = 0;
   int cal_pulses = 0;
   always #5 clk = ~clk;
   // Open-drain line with pull-up
   assign good_pin = good_oe ? good_out : 1'b1;
   always @(posedge clk)
      if (cal_start === 1'b1)
         cal_pulses++;
   output_setpoint_fault_manager #(.HICCUP_TICKS(32'h5)) dut_u (.CORE_CLK(clk), .RST(rst), .WB_REQ(req),
      .WB_ACK(ack), .WB_DAT_O(rdat), .STRAP_SENSE_PIN(strap), .CTRL_PIN(ctrl), .OVERCURRENT_PIN(oc),
      .VOUT_SENSE(vout), .RAMP_DONE(ramp_done), .CAL_DONE(cal_done), .OUTPUT_ENABLE(oe), .TARGET(target),
      .CAL_START(cal_start), .POWER_GOOD_OUT(good_out), .POWER_GOOD_OE(good_oe));
   ospfm_load_model load_u (.clk(clk), .rst(rst), .out_en(oe), .target(target), .cal_start(cal_start),
      .force_en(force_en), .force_mv(force_mv), .vout(vout), .ramp_done(ramp_done), .cal_done(cal_done));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic final_report;
      if (fails == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      d = rdat;
      req <= '0;
      check("bus ack", 1'b1, ack);
      if (ack !== 1'b1)
         final_report;
   endtask : wb
   task automatic rchk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      check(nm, exp, d);
   endtask : rchk
   task automatic tgt(input string nm, input logic [15:0] exp);
      repeat (2) @(posedge clk);
      check(nm, {16'h0000, exp}, {16'h0000, target});
   endtask : tgt
   function automatic logic level(input bit good);
      return good ? good_pin : oe;
   endfunction : level
   task automatic wait_for(input string nm, input bit good, input logic exp, input int lim);
      for (int i = 0; i < lim && level(good) !== exp; i++)
         @(posedge clk);
      check(nm, exp, level(good));
      if (level(good) !== exp)
         final_report;
   endtask : wait_for
   task automatic hold(input string nm, input bit good, input logic exp, input int cyc);
      for (int i = 0; i < cyc && level(good) === exp; i++)
         @(posedge clk);
      check(nm, exp, level(good));
   endtask : hold
   task automatic setf(input logic en, input logic [15:0] mv);
      @(posedge clk);
      force_en <= en;
      force_mv <= mv;
   endtask : setf
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset levels derived from the strap nominal, strap frozen after power-up
   task automatic t_regs;
      logic [7:0] adr [8] = '{`ADR_VCMD, `ADR_MHIGH, `ADR_MLOW, `ADR_VMAX, `ADR_OVLIM, `ADR_UVLIM, `ADR_PGON,
         `ADR_PGOFF};
      logic [7:0] pct [8] = '{8'h64, 8'h69, 8'h5f, 8'h6e, 8'h73, 8'h55, 8'h5a, 8'h55};
      for (int i = 0; i < 8; i++)
         rchk("level reg", adr[i], NOM * {24'h0, pct[i]} / 32'h64);
      rchk("responses", `ADR_RESP, {26'h0, 2'h2, 2'h3, 2'h3});
      strap <= 4'h3;
      rchk("unmapped", 8'h3c, 32'h0);
      wb(1'b1, `ADR_TARGET, 32'h1234);
      rchk("target ro", `ADR_TARGET, NOM);
      wb(1'b0, `ADR_STATUS, 32'h0);
      check("strap code", 32'h6, {28'h0, d[19:16]});
   endtask : t_regs
   // Enable, ramp, calibration, then power good
   task automatic t_start;
      @(posedge clk);
      ctrl <= 1'b1;
      wait_for("output on", 1'b0, 1'b1, 30);
      check("good in ramp", 1'b0, good_pin);
      wait_for("good high", 1'b1, 1'b1, 100);
      check("cal done", 1'b1, cal_done);
      check("cal pulses", 32'h1, cal_pulses);
   endtask : t_start
   // Command, trim, margins and clamp
   task automatic t_setpoint;
      wb(1'b1, `ADR_VCMD, 32'h4b0);
      tgt("clamped", 16'h044c);
      rchk("stored cmd", `ADR_VCMD, 32'h4b0);
      wb(1'b1, `ADR_VCMD, 32'h3fc);
      tgt("command", 16'h03fc);
      wb(1'b1, `ADR_TRIM, 32'hfff6);
      tgt("trimmed", 16'h03f2);
      wb(1'b1, `ADR_CTRL, {29'h0, `MARGIN_HIGH, 1'b1});
      tgt("margin high", 16'h0410);
      wb(1'b1, `ADR_CTRL, {29'h0, `MARGIN_LOW, 1'b1});
      tgt("margin low", 16'h03ac);
      wb(1'b1, `ADR_CTRL, 32'h1);
      wb(1'b1, `ADR_TRIM, 32'h0);
      wb(1'b1, `ADR_VMAX, 32'h3f2);
      tgt("new max", 16'h03f2);
      wb(1'b1, `ADR_VMAX, 32'h44c);
      wb(1'b1, `ADR_VCMD, NOM);
      tgt("nominal", 16'h03e8);
   endtask : t_setpoint
   // Over-voltage: threshold, automatic, latched and delayed responses
   task automatic t_ov;
      wb(1'b1, `ADR_OVLIM, 32'h4e2);
      setf(1'b1, 16'h04b0);
      hold("below new limit", 1'b0, 1'b1, 30);
      wb(1'b1, `ADR_OVLIM, 32'h47e);
      wait_for("ov off", 1'b0, 1'b0, 10);
      wait_for("good on fault", 1'b1, 1'b0, 5);
      setf(1'b0, 16'h0);
      wait_for("ov restart", 1'b0, 1'b1, 10);
      wait_for("good back", 1'b1, 1'b1, 200);
      wb(1'b1, `ADR_RESP, 32'h2e);
      setf(1'b1, 16'h04b0);
      wait_for("latch off", 1'b0, 1'b0, 10);
      setf(1'b0, 16'h0);
      hold("latch held", 1'b0, 1'b0, 50);
      wb(1'b0, `ADR_STATUS, 32'h0);
      check("ov flag", 32'h1, {31'h0, d[0]});
      wb(1'b1, `ADR_STATUS, 32'h1);
      wait_for("bus clear", 1'b0, 1'b1, 10);
      wb(1'b1, `ADR_RESP, 32'h2d);
      wb(1'b1, `ADR_DELAY, 32'h3);
      setf(1'b1, 16'h04b0);
      hold("short fault", 1'b0, 1'b1, 100);
      setf(1'b0, 16'h0);
      hold("fault gone", 1'b0, 1'b1, 20);
      setf(1'b1, 16'h04b0);
      hold("delay runs", 1'b0, 1'b1, 150);
      wait_for("delay off", 1'b0, 1'b0, 500);
      setf(1'b0, 16'h0);
      wb(1'b1, `ADR_STATUS, 32'h1);
      wait_for("delay clear", 1'b0, 1'b1, 10);
      // Under-voltage is armed only once the new ramp has finished
      wait_for("good after delay", 1'b1, 1'b1, 200);
      wb(1'b1, `ADR_RESP, 32'h2f);
      setf(1'b1, 16'h0320);
      wait_for("uv off", 1'b0, 1'b0, 10);
      setf(1'b0, 16'h0);
      wait_for("uv restart", 1'b0, 1'b1, 10);
      wait_for("good after uv", 1'b1, 1'b1, 200);
   endtask : t_ov
   // Over-current: unarmed during ramp, hiccup retry, latched shutdown
   task automatic t_oc;
      @(posedge clk);
      ctrl <= 1'b0;
      wait_for("ctrl off", 1'b0, 1'b0, 10);
      oc <= 1'b1;
      ctrl <= 1'b1;
      wait_for("ctrl on", 1'b0, 1'b1, 20);
      hold("oc unarmed", 1'b0, 1'b1, 18);
      wait_for("hiccup off", 1'b0, 1'b0, 30);
      oc <= 1'b0;
      wb(1'b0, `ADR_STATUS, 32'h0);
      check("hiccup flag", 32'h1, {31'h0, d[5]});
      hold("hiccup wait", 1'b0, 1'b0, 250);
      wait_for("hiccup retry", 1'b0, 1'b1, 500);
      wait_for("good retry", 1'b1, 1'b1, 200);
      // Over-current response set to latch, so no restart is expected
      wb(1'b1, `ADR_RESP, 32'h1f);
      oc <= 1'b1;
      wait_for("oc latch", 1'b0, 1'b0, 30);
      oc <= 1'b0;
      hold("no retry", 1'b0, 1'b0, 700);
      wb(1'b0, `ADR_STATUS, 32'h0);
      check("oc flag", 32'h1, {31'h0, d[2]});
      ctrl <= 1'b0;
      repeat (10) @(posedge clk);
      ctrl <= 1'b1;
      wait_for("re-enable", 1'b0, 1'b1, 30);
      wb(1'b0, `ADR_STATUS, 32'h0);
      check("oc flag clr", 32'h0, {31'h0, d[2]});
      wait_for("good relatch", 1'b1, 1'b1, 200);
   endtask : t_oc
   // Ignore responses and power-good hysteresis
   task automatic t_good;
      wb(1'b1, `ADR_RESP, 32'h0);
      setf(1'b1, 16'h04b0);
      hold("ov ignored", 1'b0, 1'b1, 30);
      setf(1'b1, 16'h0348);
      wait_for("good off", 1'b1, 1'b0, 10);
      check("uv ignored", 1'b1, oe);
      setf(1'b1, 16'h0366);
      hold("good below on", 1'b1, 1'b0, 30);
      setf(1'b0, 16'h0);
      wait_for("good on", 1'b1, 1'b1, 10);
      setf(1'b1, 16'h0366);
      hold("good above off", 1'b1, 1'b1, 30);
      setf(1'b0, 16'h0);
      oc <= 1'b1;
      hold("oc ignored", 1'b0, 1'b1, 30);
      oc <= 1'b0;
      // Back high first, so that the new off level alone pulls it down
      wait_for("good after oc", 1'b1, 1'b1, 10);
      wb(1'b1, `ADR_PGOFF, 32'h3f2);
      wait_for("good new off", 1'b1, 1'b0, 10);
      wb(1'b1, `ADR_PGOFF, 32'h352);
      wait_for("good restored", 1'b1, 1'b1, 10);
   endtask : t_good
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      t_regs;
      t_start;
      t_setpoint;
      t_ov;
      t_oc;
      t_good;
      final_report;
   end
endmodule : output_setpoint_fault_manager_tb_top
`default_nettype wire
